// File: testbench/mhp_frame_src.sv
// Stand-in for the demodulator that hands received frame bytes to the parser.
// Assumes the bench loads fbuf and then calls send right after a clock edge.
`timescale 1ns/100ps
module mhp_frame_src
(
	input wire logic hclk, // Clock.
	output logic rx_start, // Frame start pulse.
	output logic [6:0] rx_len, // Frame length with checksum.
	output logic rx_valid, // Byte strobe.
	output logic [7:0] rx_data // Received byte.
);
	logic [7:0] fbuf [0:127];

	// Quiet line at time zero.
	initial
	begin
		rx_start = 1'b0;
		rx_len = 7'h00;
		rx_valid = 1'b0;
		rx_data = 8'h00;
	end

	// Sends one frame with gap idle cycles before each byte.
	// Between strobes the data line toggles, so a stale byte never looks held.
	task automatic send(input logic [6:0] len, input int gap);
		int i;
		int g;
		@(posedge hclk);
		rx_start <= 1'b1;
		rx_len <= len;
		for (i = 0; i < len; i++)
			for (g = 0; g <= gap; g++)
			begin
				@(posedge hclk);
				rx_start <= 1'b0;
				rx_valid <= (g == gap);
				rx_data <= (g == gap) ? fbuf[i] : ~rx_data;
			end
		@(posedge hclk);
		rx_valid <= 1'b0;
		rx_data <= ~rx_data;
	endtask
endmodule

// File: testbench/mhp_parser_tb.sv
// Self-checking bench for the received-frame header parser.
// Assumes the parser is the only AHB-Lite slave and mhp_frame_src feeds its bytes.
`timescale 1ns/100ps
module mhp_parser_tb
	import mhp_pkg::*;
;
	typedef struct packed {logic [15:0] fcf; logic [14:0] exp;} mhp_row_t;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] rd;
	wire hrdy;
	logic hresp, rx_start, rx_valid, sec_enabled, pan_id_comp, type_std, sec_fmt_2003, sec_fmt_2006;
	logic ack_due, hdr_done, hdr_trunc;
	logic [31:0] hrdata;
	logic [6:0] rx_len;
	logic [7:0] rx_data, ack_seq;
	logic [2:0] frame_type;
	logic [1:0] dst_mode, src_mode, frame_version;
	logic [14:0] fields;
	logic [7:0] body [$];
	int num_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	// Type, flags, modes, version, derived classes, then truncation.
	mhp_row_t rows [8] = '{'{16'h0000, 15'h0008}, '{16'h8841, 15'h1688}, '{16'hCC02, 15'h23C8},
		'{16'h100B, 15'h381A}, '{16'h000C, 15'h4804}, '{16'h2C05, 15'h5320}, '{16'hB406, 15'h61B0},
		'{16'h5047, 15'h7450}};

	assign fields = {frame_type, sec_enabled, pan_id_comp, dst_mode, src_mode, frame_version, type_std,
		sec_fmt_2003, sec_fmt_2006, hdr_trunc};

	always #2 hclk = ~hclk;

	mhp_frame_src src (.hclk(hclk), .rx_start(rx_start), .rx_len(rx_len), .rx_valid(rx_valid), .rx_data(rx_data));

	mhp_parser uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata),
		.rx_start(rx_start), .rx_len(rx_len), .rx_valid(rx_valid), .rx_data(rx_data), .frame_type(frame_type),
		.sec_enabled(sec_enabled), .pan_id_comp(pan_id_comp), .dst_mode(dst_mode), .src_mode(src_mode),
		.frame_version(frame_version), .type_std(type_std), .sec_fmt_2003(sec_fmt_2003),
		.sec_fmt_2006(sec_fmt_2006), .ack_due(ack_due), .ack_seq(ack_seq), .hdr_done(hdr_done),
		.hdr_trunc(hdr_trunc));

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task report_and_stop;
		if (num_errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// One single word transfer; waits on hready in both phases, read data taken at the closing edge.
	task bus(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] r);
		@(posedge hclk);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		hsel <= 1'b1;
		do @(posedge hclk); while (hrdy !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge hclk); while (hrdy !== 1'b1);
		r = hrdata;
	endtask

	// Loads header bytes and body, sends the frame with its two checksum octets, checks the end pulse.
	task send_frame(input logic [15:0] fcf, input logic [7:0] seq, input int gap);
		src.fbuf[0] = fcf[7:0];
		src.fbuf[1] = fcf[15:8];
		src.fbuf[2] = seq;
		foreach (body[i]) src.fbuf[i + 3] = body[i];
		src.send(7'(body.size() + 5), gap);
		#1 chk("done", 32'(hdr_done), 32'h1);
		@(posedge hclk);
		#1 chk("done_end", 32'(hdr_done), 32'h0);
	endtask

	// Header octets between sequence number and payload, as the control word asks.
	function automatic int hdr_bytes(input logic [15:0] f);
		int n;
		n = 0;
		if (f[11]) n += f[10] ? 10 : 4;
		if (f[15] && !(f[6] && f[11])) n += 2;
		if (f[15]) n += f[14] ? 8 : 2;
		if (f[3]) n += 5;
		return n;
	endfunction

	// A hang ends the run here with a counted mismatch.
	always @(posedge hclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			num_errors++;
			report_and_stop();
		end
	end

	initial
	begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		bus(MHP_OFS_CTRL, 1'b0, 32'h0, rd);
		chk("ctrl_reset", rd, 32'h0);
		// Decode table; filler 0xC3 keeps any security control at five octets.
		for (int i = 0; i < 8; i++)
		begin
			body = {};
			repeat (hdr_bytes(rows[i].fcf)) body.push_back(8'hC3);
			send_frame(rows[i].fcf, 8'(8'h10 + i), i % 2);
			chk("fields", 32'(fields), 32'(rows[i].exp));
			chk("seq", 32'(ack_seq), 32'(8'h10 + i));
		end
		// Every policy against every version.
		body = {};
		for (int p = 0; p < 4; p++)
		begin
			bus(MHP_OFS_CTRL, 1'b1, 32'(p * 2 + 1), rd);
			bus(MHP_OFS_CTRL, 1'b0, 32'h0, rd);
			chk("ctrl", rd, 32'(p * 2 + 1));
			for (int v = 0; v < 4; v++)
			begin
				send_frame(16'h0021 | 16'(v << 12), 8'(v + 16 * p), 0);
				chk("ack_due", 32'(ack_due), 32'(v <= p));
				chk("ack_seq", 32'(ack_seq), 32'(v + 16 * p));
			end
		end
		bus(MHP_OFS_CTRL, 1'b1, 32'h6, rd);
		send_frame(16'h0021, 8'h00, 0);
		chk("ack_off", 32'(ack_due), 32'h0);
		// Both address fields with extended source, slow bytes, low octet first.
		body = '{8'h34, 8'h12, 8'h78, 8'h56, 8'hCD, 8'hAB, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08};
		send_frame(16'hD821, 8'h5A, 3);
		bus(MHP_OFS_FCF_SEQ, 1'b0, 32'h0, rd);
		chk("fcf_seq", rd, 32'h005AD821);
		bus(MHP_OFS_PANS, 1'b0, 32'h0, rd);
		chk("pans", rd, 32'hABCD1234);
		bus(MHP_OFS_DADR_LO, 1'b0, 32'h0, rd);
		chk("dadr", rd & 32'h0000FFFF, 32'h00005678);
		bus(MHP_OFS_SADR_LO, 1'b0, 32'h0, rd);
		chk("sadr_lo", rd, 32'h04030201);
		bus(MHP_OFS_SADR_HI, 1'b0, 32'h0, rd);
		chk("sadr_hi", rd, 32'h08070605);
		// Compression: the octets after the destination are the source address.
		body = '{8'h34, 8'h12, 8'h78, 8'h56, 8'hEF, 8'hBE};
		send_frame(16'h8841, 8'h77, 0);
		bus(MHP_OFS_SADR_LO, 1'b0, 32'h0, rd);
		chk("sadr_comp", {rd[15:0], 15'h0, hdr_trunc}, {16'hBEEF, 16'h0000});
		// Security header then a three octet payload before the footer.
		body = '{8'h05, 8'h11, 8'h22, 8'h33, 8'h44, 8'hA1, 8'hA2, 8'hA3};
		send_frame(16'h1009, 8'h01, 1);
		bus(MHP_OFS_STATUS, 1'b0, 32'h0, rd);
		chk("aux_pay", (rd >> 3) & 32'h7FFF, 32'h0283);
		// Longer security headers by key identifier mode, one payload octet each.
		for (int k = 1; k < 4; k++)
		begin
			body = {};
			body.push_back(8'(k << 3));
			repeat ((k == 1) ? 5 : (k == 2) ? 9 : 13) body.push_back(8'h00);
			body.push_back(8'hA5);
			send_frame(16'h1009, 8'(k), 0);
			bus(MHP_OFS_STATUS, 1'b0, 32'h0, rd);
			chk("aux_len", (rd >> 1) & 32'hFFFF, 32'(k << 12 | 4));
		end
		// Footer arrives where the source address should be.
		body = '{8'h34, 8'h12, 8'h78, 8'h56};
		send_frame(16'h8841, 8'h02, 0);
		bus(MHP_OFS_STATUS, 1'b0, 32'h0, rd);
		chk("trunc", {rd[1], hdr_trunc}, 32'h3);
		// Unmapped place reads zero after a write.
		bus(8'h20, 1'b1, 32'hFFFFFFFF, rd);
		bus(8'h20, 1'b0, 32'h0, rd);
		chk("unmapped", rd, 32'h0);
		chk("hresp", 32'(hresp), 32'h0);
		// Reset in mid-run clears fields and the control register.
		@(posedge hclk);
		hresetn <= 1'b0;
		@(posedge hclk);
		// Type zero still passes by default, so only the type_std bit stays up.
		#1 chk("rst_out", 32'({fields, ack_seq, ~hrdy}), 32'h00001000);
		@(posedge hclk);
		hresetn <= 1'b1;
		bus(MHP_OFS_CTRL, 1'b0, 32'h0, rd);
		chk("ctrl_rst2", rd, 32'h0);
		report_and_stop();
	end
endmodule

// File: verilog/mhp_parser.sv
// Header parser for received 802.15.4 frames, with an AHB-Lite register slave.
// Assumes rx bytes arrive on hclk from the demodulator, framed by a start pulse
// that carries the frame length including the two checksum octets.
`timescale 1ns/100ps
// Behaviour
// RULE1: Bit 6 compression drops source PAN.
// RULE2: Bits 11:10 give destination addressing mode.
// RULE3: Bits 15:14 give source addressing mode.
// RULE4: Destination PAN precedes destination address.
// RULE5: Bits 13:12 give frame version.
// RULE6: Ack decision uses version and policy.
// RULE7: Policy acknowledges versions up to setting.
// RULE8: Octet after control is sequence number.
// RULE9: Destination fields come before source fields.
// RULE10: Security header only when bit 3 set.
// RULE11: Last two octets are checksum footer.
// RULE12: Filter gets control bits 0-3,6,10-15.
// RULE13: Classify 2003 and 2006 secured formats.
// RULE14: Bits 2:0 type; types 0-3 pass.
// RULE15: Multi-octet fields arrive low octet first.
module mhp_parser
	import mhp_pkg::*;
(
	input wire logic hclk, // Clock.
	input wire logic hresetn, // Async reset, active low.
	input wire logic hsel, // Slave select.
	input wire logic [7:0] haddr, // Byte address.
	input wire logic [1:0] htrans, // Transfer type.
	input wire logic hwrite, // Write when high.
	input wire logic [2:0] hsize, // Word only.
	input wire logic [31:0] hwdata, // Write data.
	input wire logic hready, // Bus ready.
	output logic hreadyout, // Always ready.
	output logic hresp, // Always OKAY.
	output logic [31:0] hrdata, // Read data.
	input wire logic rx_start, // Frame start pulse.
	input wire logic [6:0] rx_len, // Frame length with checksum.
	input wire logic rx_valid, // Byte strobe.
	input wire logic [7:0] rx_data, // Received byte.
	output logic [2:0] frame_type, // Frame type.
	output logic sec_enabled, // Security enabled.
	output logic pan_id_comp, // PAN ID compression.
	output logic [1:0] dst_mode, // Destination addressing mode.
	output logic [1:0] src_mode, // Source addressing mode.
	output logic [1:0] frame_version, // Frame version.
	output logic type_std, // Type passes by default.
	output logic sec_fmt_2003, // 2003 secured format.
	output logic sec_fmt_2006, // 2006 secured format.
	output logic ack_due, // Ack should be sent.
	output logic [7:0] ack_seq, // Sequence for ack.
	output logic hdr_done, // Frame end pulse.
	output logic hdr_trunc // Header cut by footer.
);
	typedef struct packed {
		mhp_state_t st;
		logic [3:0] idx;
		logic [3:0] flen;
		logic [6:0] rem;
		logic [15:0] fcf;
		logic [7:0] seq;
		logic [15:0] dpan;
		logic [15:0] span;
		logic [63:0] dadr;
		logic [63:0] sadr;
		logic [7:0] auxctl;
		logic [6:0] paylen;
		logic done;
		logic trunc;
		logic aack;
		logic [1:0] policy;
		logic a_wr;
		logic [7:0] a_addr;
		logic [31:0] rdata;
	} mhp_regs_t;

	mhp_regs_t r;
	mhp_regs_t next_r;

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	// Address field length for a mode; every mode but extended, reserved included, gives the two-octet length.
	function automatic logic [3:0] mhp_adr_len(input logic [1:0] m);
		return (m == MHP_MODE_EXT) ? MHP_LEN_EXT : MHP_LEN_WORD;
	endfunction

	// State after the source fields.
	function automatic mhp_state_t mhp_after_src(input logic [15:0] f);
		return f[MHP_SEC_BIT] ? MHP_AUX : MHP_PAY; // RULE10
	endfunction

	// State after the destination fields.
	function automatic mhp_state_t mhp_after_dst(input logic [15:0] f);
		logic [1:0] dm;
		logic [1:0] sm;
		dm = f[MHP_DMODE_LSB +: 2];
		sm = f[MHP_SMODE_LSB +: 2];
		if (!sm[1])
			return mhp_after_src(f);
		if (dm[1] && f[MHP_PANC_BIT])
			return MHP_SADR; // RULE1
		return MHP_SPAN;
	endfunction

	// Length of the field that a state collects.
	function automatic logic [3:0] mhp_len_of(input mhp_state_t s, input logic [15:0] f);
		unique case (s)
			MHP_DADR: return mhp_adr_len(f[MHP_DMODE_LSB +: 2]);
			MHP_SADR: return mhp_adr_len(f[MHP_SMODE_LSB +: 2]);
			MHP_SEQ: return MHP_LEN_SEQ;
			MHP_AUX: return MHP_LEN_SEQ;
			default: return MHP_LEN_WORD;
		endcase
	endfunction

	// Total auxiliary header length from its control octet.
	function automatic logic [3:0] mhp_aux_len(input logic [7:0] c);
		unique case (c[MHP_KEYID_LSB +: 2])
			2'h0: return MHP_AUX_LEN0;
			2'h1: return MHP_AUX_LEN1;
			2'h2: return MHP_AUX_LEN2;
			default: return MHP_AUX_LEN3;
		endcase
	endfunction

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	// The parser and the bus slave share one state record.
	always_comb
	begin
		logic [6:0] rem_n;
		logic last;
		mhp_state_t nst;
		rem_n = r.rem - 7'h01;
		last = (r.idx + 4'h1) == r.flen;
		nst = r.st;
		next_r = r;
		next_r.done = 1'b0;
		if (rx_start)
		begin
			next_r.st = MHP_FCF;
			next_r.idx = 4'h0;
			next_r.flen = MHP_LEN_WORD;
			next_r.rem = rx_len;
			next_r.fcf = 16'h0000;
			next_r.dpan = 16'h0000;
			next_r.span = 16'h0000;
			next_r.dadr = 64'h0;
			next_r.sadr = 64'h0;
			next_r.auxctl = 8'h00;
			next_r.paylen = 7'h00;
			next_r.trunc = 1'b0;
		end
		else if (rx_valid && r.st != MHP_IDLE)
		begin
			next_r.rem = rem_n;
			next_r.idx = r.idx + 4'h1;
			// Little-endian assembly into each field.
			unique case (r.st)
				MHP_FCF: next_r.fcf[r.idx[0]*8 +: 8] = rx_data; // RULE15
				MHP_SEQ: next_r.seq = rx_data; // RULE8
				MHP_DPAN: next_r.dpan[r.idx[0]*8 +: 8] = rx_data; // RULE4 RULE15
				MHP_DADR: next_r.dadr[r.idx[2:0]*8 +: 8] = rx_data; // RULE15
				MHP_SPAN: next_r.span[r.idx[0]*8 +: 8] = rx_data; // RULE15
				MHP_SADR: next_r.sadr[r.idx[2:0]*8 +: 8] = rx_data; // RULE15
				MHP_AUX:
				begin
					if (r.idx == 4'h0)
					begin
						next_r.auxctl = rx_data;
						next_r.flen = mhp_aux_len(rx_data);
						last = 1'b0;
					end
				end
				MHP_PAY: next_r.paylen = r.paylen + 7'h01;
				default: ;
			endcase
			// Field sequencing: destination before source before security.
			if (last)
			begin
				unique case (r.st)
					MHP_FCF: nst = MHP_SEQ;
					MHP_SEQ: nst = next_r.fcf[MHP_DMODE_LSB + 1] ? MHP_DPAN : mhp_after_dst(r.fcf); // RULE2 RULE9
					MHP_DPAN: nst = MHP_DADR; // RULE4
					MHP_DADR: nst = mhp_after_dst(r.fcf); // RULE9
					MHP_SPAN: nst = MHP_SADR; // RULE3
					MHP_SADR: nst = mhp_after_src(r.fcf);
					MHP_AUX: nst = MHP_PAY;
					default: ;
				endcase
			end
			if (nst != r.st)
			begin
				next_r.idx = 4'h0;
				next_r.flen = mhp_len_of(nst, r.fcf);
			end
			// The footer is found by count, whatever the header held.
			if (rem_n == 7'h00)
			begin
				nst = MHP_IDLE;
				next_r.done = 1'b1;
			end
			else if (rem_n == MHP_LEN_FCS && r.st != MHP_FCS) // RULE11
			begin
				next_r.trunc = (nst != MHP_PAY);
				nst = MHP_FCS;
			end
			next_r.st = nst;
		end
		// Bus slave: zero wait states, data phase after the latched address.
		next_r.a_wr = 1'b0;
		if (r.a_wr)
		begin
			if (r.a_addr == MHP_OFS_CTRL)
			begin
				next_r.aack = hwdata[0];
				next_r.policy = hwdata[2:1];
			end
		end
		if (hready && hsel && htrans[1])
		begin
			next_r.a_wr = hwrite;
			next_r.a_addr = haddr;
			next_r.rdata = 32'h0;
			if (!hwrite)
			begin
				unique case (haddr)
					MHP_OFS_CTRL: next_r.rdata = {29'h0, r.policy, r.aack};
					MHP_OFS_FCF_SEQ: next_r.rdata = {8'h00, r.seq, r.fcf};
					MHP_OFS_PANS: next_r.rdata = {r.span, r.dpan};
					MHP_OFS_DADR_LO: next_r.rdata = r.dadr[31:0];
					MHP_OFS_DADR_HI: next_r.rdata = r.dadr[63:32];
					MHP_OFS_SADR_LO: next_r.rdata = r.sadr[31:0];
					MHP_OFS_SADR_HI: next_r.rdata = r.sadr[63:32];
					MHP_OFS_STATUS: next_r.rdata = {4'h0, r.st, r.auxctl, r.paylen, ack_due, r.trunc, r.st == MHP_IDLE};
					default: next_r.rdata = 32'h0;
				endcase
			end
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			r <= '{st: MHP_IDLE, default: '0};
		else
			r <= next_r;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Decoded fields go straight from the stored control word to the filter.
	assign frame_type = r.fcf[MHP_TYPE_LSB +: 3]; // RULE12 RULE14
	assign sec_enabled = r.fcf[MHP_SEC_BIT]; // RULE12
	assign pan_id_comp = r.fcf[MHP_PANC_BIT]; // RULE1 RULE12
	assign dst_mode = r.fcf[MHP_DMODE_LSB +: 2]; // RULE2
	assign src_mode = r.fcf[MHP_SMODE_LSB +: 2]; // RULE3
	assign frame_version = r.fcf[MHP_VER_LSB +: 2]; // RULE5
	assign type_std = frame_type <= MHP_TYPE_MAX_STD; // RULE14
	assign sec_fmt_2003 = sec_enabled && frame_version == MHP_VER_2003; // RULE13
	assign sec_fmt_2006 = sec_enabled && frame_version == MHP_VER_2006; // RULE13
	// Reserved versions are compared like any other, so policy 3 takes them.
	assign ack_due = r.aack && r.fcf[MHP_ACKREQ_BIT] && frame_version <= r.policy; // RULE6 RULE7
	assign ack_seq = r.seq; // RULE8
	assign hdr_done = r.done;
	assign hdr_trunc = r.trunc;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = r.rdata;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence s_byte(mhp_state_t s);
		rx_valid && !rx_start && r.st == s;
	endsequence
	property p_seq_capture;
		@(posedge hclk) disable iff (!hresetn) s_byte(MHP_SEQ) |=> ack_seq == $past(rx_data);
	endproperty
	a_seq_capture: assert property (p_seq_capture) else $error("sequence not captured"); // RULE8
	property p_fcf_lsb;
		@(posedge hclk) disable iff (!hresetn) s_byte(MHP_FCF) ##1 s_byte(MHP_FCF) |=> r.fcf[15:8] == $past(rx_data);
	endproperty
	a_fcf_lsb: assert property (p_fcf_lsb) else $error("control word order wrong"); // RULE15
	property p_dst_first;
		@(posedge hclk) disable iff (!hresetn) $rose(r.st == MHP_SPAN) |-> $past(r.st) != MHP_SEQ || !dst_mode[1];
	endproperty
	a_dst_first: assert property (p_dst_first) else $error("source before destination"); // RULE9
	property p_pan_comp;
		@(posedge hclk) disable iff (!hresetn) r.st == MHP_SPAN |-> !(pan_id_comp && dst_mode[1]);
	endproperty
	a_pan_comp: assert property (p_pan_comp) else $error("source PAN parsed under compression"); // RULE1
	property p_aux_only_sec;
		@(posedge hclk) disable iff (!hresetn) r.st == MHP_AUX |-> sec_enabled;
	endproperty
	a_aux_only_sec: assert property (p_aux_only_sec) else $error("security header without bit 3"); // RULE10
	property p_footer;
		@(posedge hclk) disable iff (!hresetn) rx_valid && !rx_start && r.rem == MHP_LEN_FCS + 7'h01 && r.st != MHP_IDLE
			|=> r.st == MHP_FCS;
	endproperty
	a_footer: assert property (p_footer) else $error("footer not entered"); // RULE11
	property p_ack_policy;
		@(posedge hclk) disable iff (!hresetn) ack_due |-> r.policy == 2'h3 || frame_version <= r.policy;
	endproperty
	a_ack_policy: assert property (p_ack_policy) else $error("ack beyond policy"); // RULE7
	property p_sec_class;
		@(posedge hclk) disable iff (!hresetn) sec_fmt_2006 |-> sec_enabled && !sec_fmt_2003 && frame_version == 2'h1;
	endproperty
	a_sec_class: assert property (p_sec_class) else $error("secured format wrong"); // RULE13
	property p_type_std;
		@(posedge hclk) disable iff (!hresetn) type_std == !r.fcf[2];
	endproperty
	a_type_std: assert property (p_type_std) else $error("type pass wrong"); // RULE14
endmodule

// File: verilog/mhp_pkg.sv
// Constants shared by the received-frame header parser.
// Assumes one clock domain and a byte stream from the receiver on that clock.
package mhp_pkg;
	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] MHP_OFS_CTRL = 8'h00;
	localparam logic [7:0] MHP_OFS_FCF_SEQ = 8'h04;
	localparam logic [7:0] MHP_OFS_PANS = 8'h08;
	localparam logic [7:0] MHP_OFS_DADR_LO = 8'h0C;
	localparam logic [7:0] MHP_OFS_DADR_HI = 8'h10;
	localparam logic [7:0] MHP_OFS_SADR_LO = 8'h14;
	localparam logic [7:0] MHP_OFS_SADR_HI = 8'h18;
	localparam logic [7:0] MHP_OFS_STATUS = 8'h1C;
	// ----------------------------------------
	// Frame control word fields
	// ----------------------------------------
	localparam int MHP_TYPE_LSB = 0;
	localparam int MHP_SEC_BIT = 3;
	localparam int MHP_ACKREQ_BIT = 5;
	localparam int MHP_PANC_BIT = 6;
	localparam int MHP_DMODE_LSB = 10;
	localparam int MHP_VER_LSB = 12;
	localparam int MHP_SMODE_LSB = 14;
	localparam logic [2:0] MHP_TYPE_MAX_STD = 3'h3;
	localparam logic [1:0] MHP_MODE_SHORT = 2'h2;
	localparam logic [1:0] MHP_MODE_EXT = 2'h3;
	localparam logic [1:0] MHP_VER_2003 = 2'h0;
	localparam logic [1:0] MHP_VER_2006 = 2'h1;
	// ----------------------------------------
	// Field lengths in octets
	// ----------------------------------------
	localparam logic [3:0] MHP_LEN_WORD = 4'h2;
	localparam logic [3:0] MHP_LEN_EXT = 4'h8;
	localparam logic [3:0] MHP_LEN_SEQ = 4'h1;
	localparam logic [6:0] MHP_LEN_FCS = 7'h02;
	// Auxiliary header length by key identifier mode: control, counter, key id.
	localparam logic [3:0] MHP_AUX_LEN0 = 4'h5;
	localparam logic [3:0] MHP_AUX_LEN1 = 4'h6;
	localparam logic [3:0] MHP_AUX_LEN2 = 4'hA;
	localparam logic [3:0] MHP_AUX_LEN3 = 4'hE;
	localparam int MHP_KEYID_LSB = 3;
	// ----------------------------------------
	// Parser states, one-hot
	// ----------------------------------------
	typedef enum logic [9:0] {
		MHP_IDLE = 10'h001,
		MHP_FCF = 10'h002,
		MHP_SEQ = 10'h004,
		MHP_DPAN = 10'h008,
		MHP_DADR = 10'h010,
		MHP_SPAN = 10'h020,
		MHP_SADR = 10'h040,
		MHP_AUX = 10'h080,
		MHP_PAY = 10'h100,
		MHP_FCS = 10'h200
	} mhp_state_t;
endpackage
